// *** rtl/vmc_defs.svh ***
// register offsets, field positions, reset values and codes of the vcpu maintenance block
`ifndef VMC_DEFS_SVH
`define VMC_DEFS_SVH
`define VMC_ADDR_W 8
`define VMC_OFS_CTRL 8'h00
`define VMC_OFS_TYPE 8'h04
`define VMC_OFS_STAT 8'h08
`define VMC_OFS_MASK 8'h0c
`define VMC_B_EN 0
`define VMC_B_UNDER 1
`define VMC_B_MISSING 2
`define VMC_B_NOPEND 3
`define VMC_B_G0ON 4
`define VMC_B_G0OFF 5
`define VMC_COND_LSB 1
`define VMC_COND_MSB 5
`define VMC_NCOND 5
`define VMC_EOI_HI 31
`define VMC_EOI_LO 27
`define VMC_PRI_HI 31
`define VMC_PRI_LO 29
`define VMC_PRE_HI 28
`define VMC_PRE_LO 26
`define VMC_LRC_HI 5
`define VMC_LRC_LO 0
`define VMC_MASK_RST 5'h00
`define VMC_EOI_RST 5'h00
`define VMC_EOI_STEP 5'h01
`define VMC_ID_W 10
`define VMC_SPURIOUS_ID 10'h3ff
`define VMC_RESP_OKAY 2'h0
`define VMC_RESP_DECERR 2'h3
`endif

// *** rtl/vmc_pkg.sv ***
// types shared by the vcpu maintenance block
package vmc_pkg;
  // control register fields held by the block
  typedef struct packed {
    logic [4:0] eoi_cnt;
    logic g0_off;
    logic g0_on;
    logic no_pend;
    logic missing;
    logic under;
    logic en;
  } vmc_ctrl_t;
  // write channel phase
  typedef enum logic {WR_COLLECT, WR_RESP} vmc_wr_phase_t;
  typedef logic [2:0] vmc_lvl_t;
  typedef logic [5:0] vmc_lrc_t;
endpackage : vmc_pkg

// *** rtl/vmc_sticky.sv ***
// sticky event bits, cleared by a read, a new event wins over the clear
`timescale 1ns/1ns
module vmc_sticky
  import vmc_pkg::*;
#(
  parameter int W = 5
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] set_i,
  input wire logic clr_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] bits;
  } vmc_sticky_t;
  vmc_sticky_t st;
  vmc_sticky_t next_st;
  // set beats clear so an event in the read cycle is kept
  always_comb
  begin
    next_st = st;
    if (clr_i)
      next_st.bits = set_i;
    else
      next_st.bits = st.bits | set_i;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st <= '0;
    else
      st <= next_st;
  end
  assign q_o = st.bits;
endmodule : vmc_sticky

// *** rtl/vmc_ctrl.sv ***
// vcpu interface control, type register and maintenance interrupt over axi4-lite
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "vmc_defs.svh"
// How it works
// [RQ1] control bit 5 raises maintenance while the vm group 0 enable is off
// [RQ2] control bit 4 raises maintenance while the vm group 0 enable is on
// [RQ3] control bit 3 raises maintenance while no list entry is pending
// [RQ4] control bit 2 raises maintenance while the unmatched eoi count is nonzero
// [RQ5] control bit 1 raises maintenance when at most one list entry is valid
// [RQ6] control bit 0 is the global enable of the interface
// [RQ7] global enable off suppresses every maintenance interrupt; only MAINT_IRQ_O is gated here, IRQ_O still follows set status bits
// [RQ8] global enable off suppresses every virtual interrupt
// [RQ9] global enable off makes acknowledge reads return the spurious id
// [RQ10] type register is read-only with priority, preemption and list counts
// [RQ11] priority field sits in type bits 31 to 29
// [RQ12] preemption field sits in type bits 28 to 26
// [RQ13] list count sits in bits 5 to 0, bits 25 to 6 read zero
// [RQ14] list count field is implemented count minus one, all ones means 64
// [RQ15] priority and preemption fields hold bit count minus one, three bits each, five priority bits by default
// [RQ16] eoi without list entry that clears an active bit bumps the count
// [RQ17] maintenance output is the gated or of conditions, one cycle later
module vmc_ctrl
  import vmc_pkg::*;
#(
  parameter int LR_NUM = 4,
  parameter int PRI_BITS = 5,
  parameter int PRE_BITS = 5
)
(
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic [`VMC_ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [`VMC_ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic VM_GROUP0_ON_I,
  input wire logic [LR_NUM-1:0] LR_PENDING_I,
  input wire logic [LR_NUM-1:0] LR_VALID_I,
  input wire logic EOI_NO_ENTRY_I,
  input wire logic EOI_CLR_ACTIVE_I,
  input wire logic VIRQ_REQ_I,
  output logic VIRQ_O,
  input wire logic ACK_RD_I,
  input wire logic [`VMC_ID_W-1:0] ACK_ID_I,
  output logic [`VMC_ID_W-1:0] ACK_ID_O,
  output logic ACK_VALID_O,
  output logic MAINT_IRQ_O,
  output logic IRQ_O
);
  typedef struct packed {
    vmc_wr_phase_t wph;
    logic aw_got;
    logic w_got;
    logic [`VMC_ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    vmc_ctrl_t ctrl;
    logic [`VMC_NCOND-1:0] mask;
    logic [`VMC_NCOND-1:0] cond_q;
    logic maint;
    logic irq;
    logic virq;
    logic [`VMC_ID_W-1:0] ack_id;
    logic ack_vld;
  } vmc_state_t;
  vmc_state_t st;
  vmc_state_t next_st;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic stat_clr;
  logic [`VMC_NCOND-1:0] cond;
  logic [`VMC_NCOND-1:0] stat;
  logic [LR_NUM-1:0] valid_less;
  // control fields placed in their register word
  function automatic logic [31:0] ctrl_word(input vmc_ctrl_t c);
    logic [31:0] w;
    w = '0;
    w[`VMC_EOI_HI:`VMC_EOI_LO] = c.eoi_cnt;
    w[`VMC_B_G0OFF] = c.g0_off;
    w[`VMC_B_G0ON] = c.g0_on;
    w[`VMC_B_NOPEND] = c.no_pend;
    w[`VMC_B_MISSING] = c.missing;
    w[`VMC_B_UNDER] = c.under;
    w[`VMC_B_EN] = c.en;
    return w;
  endfunction : ctrl_word
  // read-only type word, fields hold counts minus one
  function automatic logic [31:0] type_word();
    logic [31:0] w;
    w = '0;
    w[`VMC_PRI_HI:`VMC_PRI_LO] = vmc_lvl_t'(PRI_BITS - 1); // RQ11 RQ15
    w[`VMC_PRE_HI:`VMC_PRE_LO] = vmc_lvl_t'(PRE_BITS - 1); // RQ12 RQ15
    w[`VMC_LRC_HI:`VMC_LRC_LO] = vmc_lrc_t'(LR_NUM - 1); // RQ13 RQ14
    return w;
  endfunction : type_word
  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                       input logic [3:0] s);
    logic [31:0] w;
    w = old;
    for (int b = 0; b < 4; b++)
    begin
      if (s[b])
        w[b*8 +: 8] = d[b*8 +: 8];
    end
    return w;
  endfunction : merge
  // handshakes, all from registered readies
  assign aw_hs = S_AXI_AWVALID_I & st.awready;
  assign w_hs = S_AXI_WVALID_I & st.wready;
  assign ar_hs = S_AXI_ARVALID_I & st.arready;
  assign stat_clr = ar_hs && ({S_AXI_ARADDR_I[`VMC_ADDR_W-1:2], 2'b00} == `VMC_OFS_STAT);
  // at most one valid entry: clearing the lowest set bit leaves nothing
  assign valid_less = LR_VALID_I & (LR_VALID_I - LR_NUM'(1));
  // maintenance conditions, each gated by its enable and the global enable
  always_comb
  begin
    cond = '0;
    cond[`VMC_B_G0OFF-`VMC_COND_LSB] = st.ctrl.g0_off & ~VM_GROUP0_ON_I; // RQ1
    cond[`VMC_B_G0ON-`VMC_COND_LSB] = st.ctrl.g0_on & VM_GROUP0_ON_I; // RQ2
    cond[`VMC_B_NOPEND-`VMC_COND_LSB] = st.ctrl.no_pend & ~|LR_PENDING_I; // RQ3
    cond[`VMC_B_MISSING-`VMC_COND_LSB] = st.ctrl.missing & (|st.ctrl.eoi_cnt); // RQ4
    cond[`VMC_B_UNDER-`VMC_COND_LSB] = st.ctrl.under & ~|valid_less; // RQ5
    if (!st.ctrl.en) // RQ6
      cond = '0; // RQ7
  end
  // status bits catch the rising edge of each gated condition
  vmc_sticky #(
    .W(`VMC_NCOND)
  ) u_stat (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .set_i(cond & ~st.cond_q),
    .clr_i(stat_clr),
    .q_o(stat)
  );
  // next state: bus slave, registers and interrupt outputs
  always_comb
  begin
    next_st = st;
    // write address and data are taken in either order
    if (aw_hs)
    begin
      next_st.aw_got = 1'b1;
      next_st.waddr = S_AXI_AWADDR_I;
    end
    if (w_hs)
    begin
      next_st.w_got = 1'b1;
      next_st.wdata = S_AXI_WDATA_I;
      next_st.wstrb = S_AXI_WSTRB_I;
    end
    case (st.wph)
      WR_COLLECT:
      begin
        if (st.aw_got && st.w_got)
        begin
          next_st.aw_got = 1'b0;
          next_st.w_got = 1'b0;
          next_st.bvalid = 1'b1;
          next_st.bresp = `VMC_RESP_OKAY;
          next_st.wph = WR_RESP;
          if ({st.waddr[`VMC_ADDR_W-1:2], 2'b00} == `VMC_OFS_CTRL)
          begin
            logic [31:0] w;
            w = merge(ctrl_word(st.ctrl), st.wdata, st.wstrb);
            next_st.ctrl.eoi_cnt = w[`VMC_EOI_HI:`VMC_EOI_LO];
            next_st.ctrl.g0_off = w[`VMC_B_G0OFF];
            next_st.ctrl.g0_on = w[`VMC_B_G0ON];
            next_st.ctrl.no_pend = w[`VMC_B_NOPEND];
            next_st.ctrl.missing = w[`VMC_B_MISSING];
            next_st.ctrl.under = w[`VMC_B_UNDER];
            next_st.ctrl.en = w[`VMC_B_EN]; // RQ6
          end
          else if ({st.waddr[`VMC_ADDR_W-1:2], 2'b00} == `VMC_OFS_MASK)
          begin
            logic [31:0] w;
            w = merge(32'(st.mask), st.wdata, st.wstrb);
            next_st.mask = w[`VMC_NCOND-1:0];
          end
          else if ({st.waddr[`VMC_ADDR_W-1:2], 2'b00} == `VMC_OFS_TYPE)
            next_st.bresp = `VMC_RESP_OKAY; // RQ10
          else if ({st.waddr[`VMC_ADDR_W-1:2], 2'b00} == `VMC_OFS_STAT)
            next_st.bresp = `VMC_RESP_OKAY;
          else
            next_st.bresp = `VMC_RESP_DECERR;
        end
      end
      WR_RESP:
      begin
        if (S_AXI_BREADY_I)
        begin
          next_st.bvalid = 1'b0;
          next_st.wph = WR_COLLECT;
        end
      end
      default:
        next_st.wph = WR_COLLECT;
    endcase
    // hardware bump after any software write, so no eoi is lost
    if (EOI_NO_ENTRY_I && EOI_CLR_ACTIVE_I)
      next_st.ctrl.eoi_cnt = next_st.ctrl.eoi_cnt + `VMC_EOI_STEP; // RQ16
    // one outstanding write: hold readies low until the response is gone
    next_st.awready = (next_st.wph == WR_COLLECT) && !next_st.aw_got;
    next_st.wready = (next_st.wph == WR_COLLECT) && !next_st.w_got;
    // read channel
    if (st.rvalid && S_AXI_RREADY_I)
      next_st.rvalid = 1'b0;
    if (ar_hs)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `VMC_RESP_OKAY;
      if ({S_AXI_ARADDR_I[`VMC_ADDR_W-1:2], 2'b00} == `VMC_OFS_CTRL)
        next_st.rdata = ctrl_word(st.ctrl);
      else if ({S_AXI_ARADDR_I[`VMC_ADDR_W-1:2], 2'b00} == `VMC_OFS_TYPE)
        next_st.rdata = type_word(); // RQ10
      else if ({S_AXI_ARADDR_I[`VMC_ADDR_W-1:2], 2'b00} == `VMC_OFS_STAT)
        next_st.rdata = 32'(stat);
      else if ({S_AXI_ARADDR_I[`VMC_ADDR_W-1:2], 2'b00} == `VMC_OFS_MASK)
        next_st.rdata = 32'(st.mask);
      else
      begin
        next_st.rdata = '0;
        next_st.rresp = `VMC_RESP_DECERR;
      end
    end
    next_st.arready = !next_st.rvalid;
    // interrupt side, all registered one cycle after their cause
    next_st.cond_q = cond;
    next_st.maint = |cond; // RQ17
    next_st.irq = |(stat & st.mask);
    next_st.virq = VIRQ_REQ_I & st.ctrl.en; // RQ8
    next_st.ack_vld = ACK_RD_I;
    if (ACK_RD_I)
      next_st.ack_id = st.ctrl.en ? ACK_ID_I : `VMC_SPURIOUS_ID; // RQ9
  end
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
      st <= '0;
    else
      st <= next_st;
  end
  // outputs straight from the state register
  assign S_AXI_AWREADY_O = st.awready;
  assign S_AXI_WREADY_O = st.wready;
  assign S_AXI_BVALID_O = st.bvalid;
  assign S_AXI_BRESP_O = st.bresp;
  assign S_AXI_ARREADY_O = st.arready;
  assign S_AXI_RVALID_O = st.rvalid;
  assign S_AXI_RDATA_O = st.rdata;
  assign S_AXI_RRESP_O = st.rresp;
  assign VIRQ_O = st.virq;
  assign ACK_ID_O = st.ack_id;
  assign ACK_VALID_O = st.ack_vld;
  assign MAINT_IRQ_O = st.maint;
  assign IRQ_O = st.irq;
  // checks, all on the single clock
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  property p_grp0_off;
    st.ctrl.en && st.ctrl.g0_off && !VM_GROUP0_ON_I |=> MAINT_IRQ_O;
  endproperty
  a_grp0_off: assert property (p_grp0_off) else $error("group0 off maintenance missing"); // RQ1
  property p_grp0_on;
    st.ctrl.en && st.ctrl.g0_on && VM_GROUP0_ON_I |=> MAINT_IRQ_O;
  endproperty
  a_grp0_on: assert property (p_grp0_on) else $error("group0 on maintenance missing"); // RQ2
  property p_no_pend;
    st.ctrl.en && st.ctrl.no_pend && (LR_PENDING_I == '0) |=> MAINT_IRQ_O;
  endproperty
  a_no_pend: assert property (p_no_pend) else $error("no pending maintenance missing"); // RQ3
  property p_missing;
    st.ctrl.en && st.ctrl.missing && (st.ctrl.eoi_cnt != '0) |=> MAINT_IRQ_O;
  endproperty
  a_missing: assert property (p_missing) else $error("eoi count maintenance missing"); // RQ4
  property p_under;
    st.ctrl.en && st.ctrl.under && ($countones(LR_VALID_I) <= 1) |=> MAINT_IRQ_O;
  endproperty
  a_under: assert property (p_under) else $error("underflow maintenance missing"); // RQ5
  property p_off_quiet;
    !st.ctrl.en |=> !MAINT_IRQ_O && !VIRQ_O;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("output while disabled"); // RQ7 RQ8
  property p_spurious;
    ACK_RD_I && !st.ctrl.en |=> ACK_VALID_O && (ACK_ID_O == `VMC_SPURIOUS_ID);
  endproperty
  a_spurious: assert property (p_spurious) else $error("real id while disabled"); // RQ9
  property p_eoi_bump;
    EOI_NO_ENTRY_I && EOI_CLR_ACTIVE_I && !(st.aw_got && st.w_got && st.wph == WR_COLLECT)
      |=> st.ctrl.eoi_cnt == $past(st.ctrl.eoi_cnt) + `VMC_EOI_STEP;
  endproperty
  a_eoi_bump: assert property (p_eoi_bump) else $error("eoi count not bumped"); // RQ16
  property p_type_read;
    ar_hs && ({S_AXI_ARADDR_I[`VMC_ADDR_W-1:2], 2'b00} == `VMC_OFS_TYPE)
      |=> S_AXI_RVALID_O && (S_AXI_RDATA_O[`VMC_LRC_HI:`VMC_LRC_LO] == vmc_lrc_t'(LR_NUM - 1))
          && (S_AXI_RDATA_O[`VMC_PRI_HI:`VMC_PRI_LO] == vmc_lvl_t'(PRI_BITS - 1))
          && (S_AXI_RDATA_O[`VMC_PRE_HI:`VMC_PRE_LO] == vmc_lvl_t'(PRE_BITS - 1))
          && (S_AXI_RDATA_O[`VMC_PRE_LO-1:`VMC_LRC_HI+1] == '0);
  endproperty
  a_type_read: assert property (p_type_read) else $error("type register wrong"); // RQ11 RQ12 RQ13 RQ14
  property p_quiet_idle;
    st.ctrl.en && !(st.ctrl.g0_off && !VM_GROUP0_ON_I) && !(st.ctrl.g0_on && VM_GROUP0_ON_I)
      && !(st.ctrl.no_pend && (LR_PENDING_I == '0))
      && !(st.ctrl.missing && (st.ctrl.eoi_cnt != '0))
      && !(st.ctrl.under && ($countones(LR_VALID_I) <= 1)) |=> !MAINT_IRQ_O;
  endproperty
  a_quiet_idle: assert property (p_quiet_idle) else $error("maintenance without cause"); // RQ17
  c_write_done: cover property (S_AXI_BVALID_O && S_AXI_BREADY_I);
  c_stat_read: cover property (stat_clr && (stat != '0));
  c_maint_rise: cover property (!MAINT_IRQ_O ##1 MAINT_IRQ_O);
  c_spurious: cover property (ACK_VALID_O && ACK_ID_O == `VMC_SPURIOUS_ID);
endmodule : vmc_ctrl

// *** verification/vmc_vm_model.sv ***
// far-side model: vm processor driving list state, eoi and ack strobes
`timescale 1ns/1ns
`include "vmc_defs.svh"
module vmc_vm_model
  import vmc_pkg::*;
#(
  parameter int LR_NUM = 4
)
(
  input wire logic clk_i,
  output logic grp0_o,
  output logic [LR_NUM-1:0] pend_o,
  output logic [LR_NUM-1:0] valid_o,
  output logic eoi_ne_o,
  output logic eoi_ca_o,
  output logic virq_o,
  output logic ack_rd_o,
  output logic [`VMC_ID_W-1:0] ack_id_o
);
  // quiet lines at time zero
  initial
  begin
    {virq_o, grp0_o, pend_o, valid_o} = '0;
    {eoi_ne_o, eoi_ca_o, ack_rd_o} = 3'h0;
    ack_id_o = '0;
  end
  // level state {virq request, group 0 on, pending, valid}
  task automatic set_vm(input logic [9:0] s);
    @(posedge clk_i);
    virq_o <= s[9];
    grp0_o <= s[8];
    pend_o <= LR_NUM'(s[7:4]);
    valid_o <= LR_NUM'(s[3:0]);
  endtask : set_vm
  // one-cycle eoi strobe pair
  task automatic eoi(input logic ne, input logic ca);
    @(posedge clk_i);
    eoi_ne_o <= ne;
    eoi_ca_o <= ca;
    @(posedge clk_i);
    eoi_ne_o <= 1'b0;
    eoi_ca_o <= 1'b0;
  endtask : eoi
  // id is not held after the strobe, so late sampling shows up
  task automatic ack(input logic [9:0] id);
    @(posedge clk_i);
    ack_rd_o <= 1'b1;
    ack_id_o <= id;
    @(posedge clk_i);
    ack_rd_o <= 1'b0;
    ack_id_o <= ~id;
  endtask : ack
endmodule : vmc_vm_model

// *** verification/vmc_ctrl_tb.sv ***
// self-checking bench of the vcpu maintenance control block
`timescale 1ns/1ns
`include "vmc_defs.svh"
module vmc_ctrl_tb
  import vmc_pkg::*;
;
  localparam int LRN = 4;
  localparam logic [31:0] TYPE_EXP = {3'h4, 3'h4, 20'h00000, 6'(LRN - 1)};
  logic clk;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, virq, ack_valid, maint, irq;
  logic grp0, eoi_ne, eoi_ca, virq_req, ack_rd;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  logic [9:0] ack_id, ack_id_in;
  logic [LRN-1:0] pend, valid;
  // per condition bit: state with it false, state with it true
  logic [9:0] st_f [1:5] = '{10'h1f3, 10'h000, 10'h14f, 10'h0ff, 10'h1ff};
  logic [9:0] st_t [1:5] = '{10'h1f1, 10'h000, 10'h10f, 10'h1ff, 10'h0ff};
  int fail_count = 0;
  int num_checks = 0;

  vmc_ctrl #(.LR_NUM(LRN)) dut (.SYS_CLK_I(clk), .RST_I(rst),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .VM_GROUP0_ON_I(grp0),
    .LR_PENDING_I(pend), .LR_VALID_I(valid), .EOI_NO_ENTRY_I(eoi_ne),
    .EOI_CLR_ACTIVE_I(eoi_ca), .VIRQ_REQ_I(virq_req), .VIRQ_O(virq),
    .ACK_RD_I(ack_rd), .ACK_ID_I(ack_id_in), .ACK_ID_O(ack_id),
    .ACK_VALID_O(ack_valid), .MAINT_IRQ_O(maint), .IRQ_O(irq));

  vmc_vm_model #(.LR_NUM(LRN)) model (.clk_i(clk), .grp0_o(grp0), .pend_o(pend),
    .valid_o(valid), .eoi_ne_o(eoi_ne), .eoi_ca_o(eoi_ca), .virq_o(virq_req),
    .ack_rd_o(ack_rd), .ack_id_o(ack_id_in));

  // 250 mhz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // a bounded wait ran out: count it and stop
  task automatic hang;
    chk("bus answer", 32'h1, 32'h0);
    conclude();
  endtask : hang

  // axi write; each channel drops only at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (bvalid !== 1'b1) hang();
    chk("write response", {30'h0, er}, {30'h0, bresp});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (rvalid !== 1'b1) hang();
    q = rdata;
    chk("read response", {30'h0, er}, {30'h0, rresp});
  endtask : rd

  // registered outputs lag their inputs; let them land
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`VMC_OFS_CTRL, `VMC_RESP_OKAY, d);
    chk("control reset", 32'h0, d);
    rd(`VMC_OFS_TYPE, `VMC_RESP_OKAY, d);
    chk("type", TYPE_EXP, d);
    wr(`VMC_OFS_TYPE, 32'hffffffff, `VMC_RESP_OKAY);
    rd(`VMC_OFS_TYPE, `VMC_RESP_OKAY, d);
    chk("type after write", TYPE_EXP, d);
    rd(8'h10, `VMC_RESP_DECERR, d);
    chk("unmapped read", 32'h0, d);
    wr(8'h10, 32'h1, `VMC_RESP_DECERR);
    // only an unmatched eoi that clears an active bit may count
    model.set_vm(10'h3ff);
    wr(`VMC_OFS_CTRL, 32'h5, `VMC_RESP_OKAY);
    settle;
    chk("maint count zero", 32'h0, {31'h0, maint});
    chk("virq enabled", 32'h1, {31'h0, virq});
    model.eoi(1'b1, 1'b0);
    model.eoi(1'b0, 1'b1);
    settle;
    chk("maint half eoi", 32'h0, {31'h0, maint});
    model.eoi(1'b1, 1'b1);
    settle;
    chk("maint count set", 32'h1, {31'h0, maint});
    rd(`VMC_OFS_CTRL, `VMC_RESP_OKAY, d);
    chk("control count", 32'h08000005, d);
    model.ack(10'h05a);
    #1;
    chk("ack valid", 32'h1, {31'h0, ack_valid});
    chk("ack id", 32'h05a, {22'h0, ack_id});
    wr(`VMC_OFS_CTRL, 32'h08000004, `VMC_RESP_OKAY);
    settle;
    chk("maint disabled", 32'h0, {31'h0, maint});
    chk("virq disabled", 32'h0, {31'h0, virq});
    model.ack(10'h05a);
    #1;
    chk("ack id disabled", {22'h0, `VMC_SPURIOUS_ID}, {22'h0, ack_id});
    @(posedge clk);
    #1;
    chk("ack pulse end", 32'h0, {31'h0, ack_valid});
    // each condition bit alone except bit 2: false, true, then enable dropped
    for (int k = 1; k <= 5; k++)
    begin
      if (k == 2) continue;
      model.set_vm(st_f[k]);
      wr(`VMC_OFS_CTRL, 32'h1 | (32'h1 << k), `VMC_RESP_OKAY);
      settle;
      chk("maint cond off", 32'h0, {31'h0, maint});
      model.set_vm(st_t[k]);
      settle;
      chk("maint cond on", 32'h1, {31'h0, maint});
      wr(`VMC_OFS_CTRL, 32'h1 << k, `VMC_RESP_OKAY);
      settle;
      chk("maint no enable", 32'h0, {31'h0, maint});
    end
    // sticky status, mask and clear on read
    rd(`VMC_OFS_STAT, `VMC_RESP_OKAY, d);
    wr(`VMC_OFS_MASK, 32'h1f, `VMC_RESP_OKAY);
    rd(`VMC_OFS_MASK, `VMC_RESP_OKAY, d);
    chk("mask", 32'h1f, d);
    model.set_vm(10'h1f1);
    wr(`VMC_OFS_CTRL, 32'h3, `VMC_RESP_OKAY);
    settle;
    chk("irq raised", 32'h1, {31'h0, irq});
    // status takes no writes; the read below must still show only bit 0
    wr(`VMC_OFS_STAT, 32'h1e, `VMC_RESP_OKAY);
    rd(`VMC_OFS_STAT, `VMC_RESP_OKAY, d);
    chk("status", 32'h1, d);
    settle;
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(`VMC_OFS_MASK, 32'h0, `VMC_RESP_OKAY);
    wr(`VMC_OFS_CTRL, 32'h1, `VMC_RESP_OKAY);
    wr(`VMC_OFS_CTRL, 32'h3, `VMC_RESP_OKAY);
    settle;
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`VMC_OFS_MASK, 32'h1, `VMC_RESP_OKAY);
    settle;
    chk("irq unmasked", 32'h1, {31'h0, irq});
    rd(`VMC_OFS_STAT, `VMC_RESP_OKAY, d);
    settle;
    chk("irq cleared again", 32'h0, {31'h0, irq});
    conclude();
  end
endmodule : vmc_ctrl_tb
